// File: hdl/mpps_pkg.sv
// constants and types shared by the phase sequencing and shedding block
package mpps_pkg;
  // ********************************************
  // register map (byte addresses)
  // ********************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_MP_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_SP_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_COMMAND = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DUTY = 8'h14;
  // ********************************************
  // field positions
  // ********************************************
  localparam int CFG_SHED_BIT = 0;
  localparam int CFG_DIODE_BIT = 1;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_DECAY_BIT = 2;
  localparam int DUTY_SP_LSB = 16;
  // ********************************************
  // reset values, phase limit and response codes
  // ********************************************
  localparam logic [1:0] CONFIG_RESET = 2'h0;
  localparam logic [15:0] MP_PERIOD_RESET = 16'h0064;
  localparam logic [15:0] SP_PERIOD_RESET = 16'h0050;
  localparam logic [15:0] MP_DUTY_RESET = 16'h0010;
  localparam logic [15:0] SP_DUTY_RESET = 16'h0010;
  localparam logic [2:0] PHASES_MAX = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ********************************************
  // power state command codes
  // ********************************************
  localparam logic [1:0] CODE_FULL = 2'h0;
  localparam logic [1:0] CODE_LOW = 2'h1;
  localparam logic [1:0] CODE_VERY_LOW = 2'h2;
  localparam logic [1:0] CODE_ULTRA_LOW = 2'h3;
  // ********************************************
  // types
  // ********************************************
  typedef enum logic [1:0] {
    MODE_FULL = 2'h0,
    MODE_LOW = 2'h1,
    MODE_VERY_LOW = 2'h3
  } mpps_mode_t;
  // one phase pin: out/oe is the logic drive, mid asks the pad for the mid level
  typedef struct packed {
    logic out;
    logic oe;
    logic mid;
  } mpps_pin_t;
endpackage

// File: hdl/mpps_top.sv
// multiphase phase sequencing, strap detection and phase shedding
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module mpps_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // phase pins, read back for the strap
  input wire logic phase_in_one,
  input wire logic phase_in_two,
  input wire logic phase_in_three,
  input wire logic phase_in_four,
  input wire logic single_rail_in,
  output mpps_pkg::mpps_pin_t phase_out_one,
  output mpps_pkg::mpps_pin_t phase_out_two,
  output mpps_pkg::mpps_pin_t phase_out_three,
  output mpps_pkg::mpps_pin_t phase_out_four,
  output mpps_pkg::mpps_pin_t single_rail_phase_out,
  // board and analog status
  input wire logic coupling_select_pin,
  input wire logic power_enable_in,
  input wire logic bus_rail_enable_in,
  input wire logic soft_start_done,
  input wire logic fault_in,
  input wire logic burst_demand,
  // status outputs
  output logic regulator_ready,
  output logic [3:0] channel_current_sense,
  output logic single_addr_released
);
  // ********************************************
  // declarations
  // ********************************************
  logic [7:0] aw_addr;
  logic aw_held;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] cfg;
  logic [15:0] mp_period;
  logic [15:0] sp_period;
  logic [31:0] duty;
  logic strap_done;
  logic [2:0] n_phase;
  logic sp_off;
  logic [2:0] strap_n;
  mpps_pkg::mpps_mode_t req_mode;
  mpps_pkg::mpps_mode_t cur_mode;
  logic decaying;
  logic [2:0] act_n;
  logic [1:0] partner;
  logic [15:0] slot_len;
  logic [15:0] slot_cnt;
  logic [1:0] sidx;
  logic [1:0] fire_phase;
  logic slot_wrap;
  logic pulse_on;
  logic skip;
  logic [15:0] sp_cnt;
  logic enabled;
  logic diode_on;
  logic wr_fire;
  logic [31:0] next_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [3:0] phase_rd;
  mpps_pkg::mpps_pin_t [3:0] phase_drv;

  assign phase_rd = {phase_in_four, phase_in_three, phase_in_two, phase_in_one};
  assign enabled = power_enable_in & bus_rail_enable_in;

  // ********************************************
  // axi4-lite slave
  // ********************************************
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mpps_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == mpps_pkg::ADDR_CONFIG || aw_addr == mpps_pkg::ADDR_MP_PERIOD ||
          aw_addr == mpps_pkg::ADDR_SP_PERIOD || aw_addr == mpps_pkg::ADDR_COMMAND ||
          aw_addr == mpps_pkg::ADDR_DUTY) begin
        s_axi_bresp <= mpps_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= mpps_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane merge of the held write into whichever register the held address picks
  always_comb begin
    if (aw_addr == mpps_pkg::ADDR_CONFIG) begin
      next_word = merge({30'h0, cfg}, w_data, w_strb);
    end else if (aw_addr == mpps_pkg::ADDR_MP_PERIOD) begin
      next_word = merge({16'h0, mp_period}, w_data, w_strb);
    end else if (aw_addr == mpps_pkg::ADDR_SP_PERIOD) begin
      next_word = merge({16'h0, sp_period}, w_data, w_strb);
    end else begin
      next_word = merge(duty, w_data, w_strb);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= mpps_pkg::CONFIG_RESET;
      mp_period <= mpps_pkg::MP_PERIOD_RESET;
      sp_period <= mpps_pkg::SP_PERIOD_RESET;
      duty <= {mpps_pkg::SP_DUTY_RESET, mpps_pkg::MP_DUTY_RESET};
    end else if (wr_fire) begin
      if (aw_addr == mpps_pkg::ADDR_CONFIG) begin
        cfg <= next_word[1:0];
      end else if (aw_addr == mpps_pkg::ADDR_MP_PERIOD) begin
        mp_period <= next_word[15:0];
      end else if (aw_addr == mpps_pkg::ADDR_SP_PERIOD) begin
        sp_period <= next_word[15:0];
      end else if (aw_addr == mpps_pkg::ADDR_DUTY) begin
        duty <= next_word;
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == mpps_pkg::ADDR_CONFIG) begin
      rd_word = {30'h0, cfg};
    end else if (s_axi_araddr == mpps_pkg::ADDR_MP_PERIOD) begin
      rd_word = {16'h0, mp_period};
    end else if (s_axi_araddr == mpps_pkg::ADDR_SP_PERIOD) begin
      rd_word = {16'h0, sp_period};
    end else if (s_axi_araddr == mpps_pkg::ADDR_COMMAND) begin
      rd_word = {27'h0, decaying, cur_mode, req_mode};
    end else if (s_axi_araddr == mpps_pkg::ADDR_STATUS) begin
      rd_word = {19'h0, diode_on, single_addr_released, channel_current_sense, act_n, n_phase, strap_done};
    end else if (s_axi_araddr == mpps_pkg::ADDR_DUTY) begin
      rd_word = duty;
    end else begin
      rd_word = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= mpps_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? mpps_pkg::RESP_OKAY : mpps_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ********************************************
  // strap capture
  // ********************************************
  // pins stay undriven until the first clock after reset, so the strap is read clean
  always_comb begin
    strap_n = mpps_pkg::PHASES_MAX;
    for (int p = 3; p >= 0; p--) begin
      if (phase_rd[p]) begin
        strap_n = p[2:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done <= 1'b0;
      n_phase <= 3'h0;
      sp_off <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      n_phase <= strap_n;
      sp_off <= single_rail_in;
    end
  end

  assign single_addr_released = strap_done && sp_off;

  generate
    for (genvar p = 0; p < 4; p++) begin : g_sense
      assign channel_current_sense[p] = strap_done && (n_phase > p);
    end
  endgenerate

  // ********************************************
  // power state tracking
  // ********************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_mode <= mpps_pkg::MODE_FULL;
      decaying <= 1'b0;
    end else if (wr_fire && aw_addr == mpps_pkg::ADDR_COMMAND && w_strb[0]) begin
      decaying <= w_data[mpps_pkg::CMD_DECAY_BIT];
      if (w_data[mpps_pkg::CMD_DECAY_BIT]) begin
        req_mode <= mpps_pkg::MODE_VERY_LOW;
      end else begin
        case (w_data[mpps_pkg::CMD_CODE_LSB +: 2])
          mpps_pkg::CODE_FULL: req_mode <= mpps_pkg::MODE_FULL;
          mpps_pkg::CODE_LOW: req_mode <= mpps_pkg::MODE_LOW;
          default: req_mode <= mpps_pkg::MODE_VERY_LOW;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_mode <= mpps_pkg::MODE_FULL;
    end else if (!regulator_ready) begin
      cur_mode <= mpps_pkg::MODE_FULL;
    end else if (slot_wrap) begin
      cur_mode <= req_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regulator_ready <= 1'b0;
    end else begin
      regulator_ready <= strap_done && enabled && soft_start_done && !fault_in;
    end
  end

  // ********************************************
  // phase count and slot length
  // ********************************************
  assign partner = (n_phase == mpps_pkg::PHASES_MAX) ? 2'h2 : 2'h1;

  always_comb begin
    case (cur_mode)
      mpps_pkg::MODE_FULL: act_n = n_phase;
      mpps_pkg::MODE_LOW: act_n = (n_phase > 3'h1 && cfg[mpps_pkg::CFG_SHED_BIT]) ? 3'h2 : ((n_phase == 3'h0) ? 3'h0 : 3'h1);
      default: act_n = (n_phase == 3'h0) ? 3'h0 : 3'h1;
    endcase
  end

  // even spacing: each active phase owns one slot of period/act_n, coupled pair gets half each
  always_comb begin
    case (act_n)
      3'h2: slot_len = mp_period >> 1;
      3'h3: slot_len = mp_period / 16'h0003;
      3'h4: slot_len = mp_period >> 2;
      default: slot_len = mp_period;
    endcase
  end

  assign fire_phase = (cur_mode == mpps_pkg::MODE_FULL) ? sidx : ((sidx == 2'h0) ? 2'h0 : partner);
  assign slot_wrap = strap_done && (act_n != 3'h0) && (slot_cnt + 16'h0001 >= slot_len);
  assign diode_on = (cur_mode == mpps_pkg::MODE_VERY_LOW) && cfg[mpps_pkg::CFG_DIODE_BIT];

  // ********************************************
  // multiphase timebase
  // ********************************************
  // a period below act_n clocks degenerates to one-clock slots; software keeps it sane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt <= 16'h0000;
      sidx <= 2'h0;
    end else if (slot_wrap) begin
      slot_cnt <= 16'h0000;
      if (regulator_ready && req_mode != cur_mode) begin
        sidx <= 2'h0;
      end else if ({1'b0, sidx} + 3'h1 >= act_n) begin
        sidx <= 2'h0;
      end else begin
        sidx <= sidx + 2'h1;
      end
    end else if (act_n != 3'h0) begin
      slot_cnt <= slot_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip <= 1'b0;
    end else if (slot_wrap) begin
      skip <= diode_on && !burst_demand;
    end
  end

  assign pulse_on = (act_n != 3'h0) && !skip && (slot_cnt < duty[15:0]);

  // ********************************************
  // single-phase timebase
  // ********************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_cnt <= 16'h0000;
    end else if (sp_cnt + 16'h0001 >= sp_period) begin
      sp_cnt <= 16'h0000;
    end else begin
      sp_cnt <= sp_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      single_rail_phase_out <= '0;
    end else if (!strap_done || sp_off) begin
      single_rail_phase_out <= '0;
    end else if (!enabled) begin
      single_rail_phase_out <= '{out: 1'b0, oe: 1'b1, mid: 1'b0};
    end else if (!soft_start_done || fault_in) begin
      single_rail_phase_out <= '{out: 1'b0, oe: 1'b0, mid: 1'b1};
    end else begin
      single_rail_phase_out <= '{out: (sp_cnt < duty[31:16]), oe: 1'b1, mid: 1'b0};
    end
  end

  // ********************************************
  // phase pin drive
  // ********************************************
  generate
    for (genvar p = 0; p < 4; p++) begin : g_phase
      logic in_use;
      always_comb begin
        case (cur_mode)
          mpps_pkg::MODE_FULL: in_use = 1'b1;
          mpps_pkg::MODE_LOW: in_use = (p == 0) || (act_n == 3'h2 && partner == p);
          default: in_use = (p == 0);
        endcase
      end
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          phase_drv[p] <= '0;
        end else if (!strap_done || n_phase <= p) begin
          phase_drv[p] <= '0;
        end else if (!enabled) begin
          phase_drv[p] <= '{out: 1'b0, oe: 1'b1, mid: 1'b0};
        end else if (!soft_start_done || fault_in) begin
          phase_drv[p] <= '{out: 1'b0, oe: 1'b0, mid: 1'b1};
        end else if (in_use) begin
          if (pulse_on && fire_phase == p) begin
            phase_drv[p] <= '{out: 1'b1, oe: 1'b1, mid: 1'b0};
          end else if (p == 0 && diode_on) begin
            phase_drv[p] <= '{out: 1'b0, oe: 1'b0, mid: 1'b1};
          end else begin
            phase_drv[p] <= '{out: 1'b0, oe: 1'b1, mid: 1'b0};
          end
        end else if (coupling_select_pin && partner == p && pulse_on && fire_phase == 2'h0) begin
          phase_drv[p] <= '{out: 1'b0, oe: 1'b1, mid: 1'b0};
        end else begin
          phase_drv[p] <= '{out: 1'b0, oe: 1'b0, mid: 1'b1};
        end
      end
    end
  endgenerate

  assign phase_out_one = phase_drv[0];
  assign phase_out_two = phase_drv[1];
  assign phase_out_three = phase_drv[2];
  assign phase_out_four = phase_drv[3];

  // ********************************************
  // assertions
  // ********************************************
  sequence wrap_in_full_s;
    slot_wrap && cur_mode == mpps_pkg::MODE_FULL && req_mode == mpps_pkg::MODE_FULL && regulator_ready;
  endsequence

  strap_count_a: assert property (@(posedge aclk) disable iff (!aresetn) $rose(strap_done) |-> n_phase == $past(strap_n)) else $error("strap count wrong");
  mp_off_a: assert property (@(posedge aclk) disable iff (!aresetn) strap_done && n_phase == 3'h0 |=> !phase_out_one.oe && !phase_out_one.mid) else $error("phase one driven while off");
  one_phase_a: assert property (@(posedge aclk) disable iff (!aresetn) strap_done && n_phase == 3'h1 |=> !phase_out_two.oe && !phase_out_four.oe) else $error("extra phase driven");
  ready_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) !regulator_ready |=> cur_mode == mpps_pkg::MODE_FULL) else $error("reduced state before ready");
  decay_enter_a: assert property (@(posedge aclk) disable iff (!aresetn) wr_fire && aw_addr == mpps_pkg::ADDR_COMMAND && w_strb[0] && w_data[2] |=> req_mode == mpps_pkg::MODE_VERY_LOW && decaying) else $error("decay not very low");
  ultra_same_a: assert property (@(posedge aclk) disable iff (!aresetn) wr_fire && aw_addr == mpps_pkg::ADDR_COMMAND && w_strb[0] && w_data[2:0] == 3'h3 |=> req_mode == mpps_pkg::MODE_VERY_LOW) else $error("ultra low differs");
  shed_edge_a: assert property (@(posedge aclk) disable iff (!aresetn) regulator_ready && $past(regulator_ready) && cur_mode != $past(cur_mode) |-> $past(slot_wrap)) else $error("mode changed mid pulse");
  deep_one_a: assert property (@(posedge aclk) disable iff (!aresetn) cur_mode == mpps_pkg::MODE_VERY_LOW && n_phase != 3'h0 |-> act_n == 3'h1) else $error("deep state not single phase");
  mid_fault_a: assert property (@(posedge aclk) disable iff (!aresetn) strap_done && n_phase != 3'h0 && enabled && fault_in |=> phase_out_one.mid && !phase_out_one.oe) else $error("no mid level on fault");
  sense_mask_a: assert property (@(posedge aclk) disable iff (!aresetn) strap_done && n_phase == 3'h2 |-> channel_current_sense == 4'h3) else $error("sense mask wrong");
  fire_order_a: assert property (@(posedge aclk) disable iff (!aresetn) wrap_in_full_s ##1 !$changed(n_phase) |-> sidx == (({1'b0, $past(sidx)} + 3'h1 >= act_n) ? 2'h0 : $past(sidx) + 2'h1)) else $error("firing order broken");
  partner_low_a: assert property (@(posedge aclk) disable iff (!aresetn) strap_done && enabled && soft_start_done && !fault_in && coupling_select_pin && cur_mode != mpps_pkg::MODE_FULL && act_n == 3'h1 && n_phase == 3'h4 && pulse_on |=> phase_out_three.oe && !phase_out_three.out) else $error("partner not low");
endmodule
`default_nettype wire

// File: sim/mpps_driver_model.sv
// driver-stage model that feeds the phase pins back for strap sensing
`timescale 1ns/100ps
`default_nettype none
module mpps_driver_model (
  // board wiring: a set bit ties that pin to the supply
  input wire logic [4:0] strap,
  // pins from the controller
  input wire mpps_pkg::mpps_pin_t pin_one,
  input wire mpps_pkg::mpps_pin_t pin_two,
  input wire mpps_pkg::mpps_pin_t pin_three,
  input wire mpps_pkg::mpps_pin_t pin_four,
  input wire mpps_pkg::mpps_pin_t pin_single,
  // level seen back on each pin
  output logic [4:0] readback
);
  // a tied pin reads high whatever the controller does; the mid level reads low
  always_comb begin
    readback[0] = strap[0] | (pin_one.oe & pin_one.out);
    readback[1] = strap[1] | (pin_two.oe & pin_two.out);
    readback[2] = strap[2] | (pin_three.oe & pin_three.out);
    readback[3] = strap[3] | (pin_four.oe & pin_four.out);
    readback[4] = strap[4] | (pin_single.oe & pin_single.out);
  end
endmodule
`default_nettype wire

// File: sim/mpps_top_test.sv
// self-checking testbench for the phase sequencing and shedding block
`timescale 1ns/100ps
`default_nettype none
module mpps_top_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cpl = 1'b0;
  logic ss = 1'b1;
  logic flt = 1'b0;
  logic [4:0] strap = 5'h00;
  logic en = 1'b1;
  logic bst = 1'b1;
  logic last_one = 1'b0;
  int rises = 0;
  int r0 = 0;
  logic awready, wready, bvalid, arready, rvalid, rdy, rel;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd_v;
  logic [3:0] sense;
  logic [4:0] rb;
  mpps_pkg::mpps_pin_t o1, o2, o3, o4, os;
  wire logic [4:0] outs = {os.out, o4.out, o3.out, o2.out, o1.out};
  logic [2:0] cmd_t [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  logic [1:0] cur_t [5] = '{2'h1, 2'h3, 2'h3, 2'h3, 2'h0};
  logic [2:0] act_t [5] = '{3'h2, 3'h1, 3'h1, 3'h1, 3'h4};
  int fails = 0;
  int checks_done = 0;
  always #25 aclk = ~aclk;
  // counts phase one pulses so that skipped pulses in burst operation show
  always @(posedge aclk) begin
    last_one <= o1.out;
    if (o1.out && !last_one) rises <= rises + 1;
  end
  mpps_top mpps_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_in_one(rb[0]), .phase_in_two(rb[1]), .phase_in_three(rb[2]), .phase_in_four(rb[3]),
    .single_rail_in(rb[4]), .phase_out_one(o1), .phase_out_two(o2), .phase_out_three(o3),
    .phase_out_four(o4), .single_rail_phase_out(os), .coupling_select_pin(cpl),
    .power_enable_in(en), .bus_rail_enable_in(en), .soft_start_done(ss), .fault_in(flt),
    .burst_demand(bst), .regulator_ready(rdy), .channel_current_sense(sense),
    .single_addr_released(rel));
  mpps_driver_model mpps_driver_model_inst (.strap(strap), .pin_one(o1), .pin_two(o2),
    .pin_three(o3), .pin_four(o4), .pin_single(os), .readback(rb));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic hang();
    fails++;
    close_out();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
    check(bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) hang();
    rd_v = rdata;
    check(rresp, er);
  endtask
  // cycles from a rising edge on phase a to the next rising edge on phase b
  task automatic gap(input int a, input int b, input int exp);
    int n;
    int c;
    logic [4:0] l;
    c = -1;
    l = outs;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (c >= 0) c++;
      if (c < 0 && outs[a] && !l[a]) c = 0;
      if (c > 0 && outs[b] && !l[b]) break;
      l = outs;
    end
    if (n == 400) hang();
    check(c, exp);
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  function automatic logic [31:0] stat(input logic [2:0] n, input logic r);
    stat = 32'h1;
    stat[3:1] = n;
    stat[6:4] = n;
    stat[10:7] = (4'h1 << n) - 4'h1;
    stat[11] = r;
  endfunction
  initial begin
    do_reset();
    rd(mpps_pkg::ADDR_CONFIG, mpps_pkg::RESP_OKAY);
    check(rd_v, 32'h0);
    rd(mpps_pkg::ADDR_MP_PERIOD, mpps_pkg::RESP_OKAY);
    check(rd_v, {16'h0, mpps_pkg::MP_PERIOD_RESET});
    rd(mpps_pkg::ADDR_DUTY, mpps_pkg::RESP_OKAY);
    check(rd_v, 32'h00100010);
    rd(8'h40, mpps_pkg::RESP_SLVERR);
    check(rd_v, 32'h0);
    wr(8'h40, 32'h1, mpps_pkg::RESP_SLVERR);
    rd(mpps_pkg::ADDR_STATUS, mpps_pkg::RESP_OKAY);
    check(rd_v, stat(3'h4, 1'b0));
    check(sense, 4'hF);
    gap(0, 1, 25);
    gap(0, 3, 75);
    gap(4, 4, 80);
    $display("test defaults done");
    // a full command last so the loop leaves every phase back in service
    wr(mpps_pkg::ADDR_CONFIG, 32'h3, mpps_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      wr(mpps_pkg::ADDR_COMMAND, {29'h0, cmd_t[i]}, mpps_pkg::RESP_OKAY);
      repeat (120) @(posedge aclk);
      rd(mpps_pkg::ADDR_COMMAND, mpps_pkg::RESP_OKAY);
      check(rd_v[4:2], {cmd_t[i][2], cur_t[i]});
      rd(mpps_pkg::ADDR_STATUS, mpps_pkg::RESP_OKAY);
      check({rd_v[12], rd_v[6:4]}, {cur_t[i] == 2'h3, act_t[i]});
      if (i == 0) gap(0, 2, 50);
      if (i == 1) begin
        bst <= 1'b0;
        repeat (100) @(posedge aclk);
        r0 = rises;
        repeat (300) @(posedge aclk);
        check(rises - r0, 0);
        bst <= 1'b1;
        repeat (100) @(posedge aclk);
        r0 = rises;
        repeat (300) @(posedge aclk);
        check(rises - r0, 3);
      end
    end
    $display("test power states done");
    cpl <= 1'b1;
    wr(mpps_pkg::ADDR_CONFIG, 32'h0, mpps_pkg::RESP_OKAY);
    wr(mpps_pkg::ADDR_COMMAND, 32'h1, mpps_pkg::RESP_OKAY);
    repeat (120) @(posedge aclk);
    gap(0, 0, 100);
    check(o3, 3'h2);
    check(o2, 3'h1);
    wr(mpps_pkg::ADDR_COMMAND, 32'h0, mpps_pkg::RESP_OKAY);
    cpl <= 1'b0;
    $display("test coupled done");
    ss <= 1'b0;
    wr(mpps_pkg::ADDR_COMMAND, 32'h2, mpps_pkg::RESP_OKAY);
    repeat (120) @(posedge aclk);
    check({rdy, o1.mid}, 2'h1);
    rd(mpps_pkg::ADDR_COMMAND, mpps_pkg::RESP_OKAY);
    check(rd_v[3:2], mpps_pkg::MODE_FULL);
    ss <= 1'b1;
    repeat (120) @(posedge aclk);
    rd(mpps_pkg::ADDR_COMMAND, mpps_pkg::RESP_OKAY);
    check(rd_v[3:2], mpps_pkg::MODE_VERY_LOW);
    flt <= 1'b1;
    repeat (3) @(posedge aclk);
    check({rdy, o1.mid}, 2'h1);
    flt <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge aclk);
    check({rdy, o1}, 4'h2);
    en <= 1'b1;
    $display("test ready and fault done");
    for (int i = 0; i < 4; i++) begin
      strap <= 5'h10 | (5'h1 << i);
      do_reset();
      rd(mpps_pkg::ADDR_STATUS, mpps_pkg::RESP_OKAY);
      check(rd_v, stat(i[2:0], 1'b1));
      check(rel, 1'b1);
      if (i == 0) check(o1, 3'h0);
      check(os, 3'h0);
      if (i == 3) gap(0, 2, 66);
    end
    $display("test straps done");
    close_out();
  end
endmodule
`default_nettype wire
